//--- shared/analog_out_pkg.sv
/*
  Constants, register map and enumerations shared by the analog output
  source select block and its helpers.
  Assumes one 200 MHz clock; voltages are signed 16-bit codes, 7fff = +10 V.
*/
`default_nettype none

package analog_out_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [15:0] ADDR_CURRENT_SCALE = 16'h0012;
  localparam logic [15:0] ADDR_SOURCE_SELECT = 16'h0014;
  localparam logic [15:0] ADDR_OFFSET        = 16'h0016;
  localparam logic [15:0] ADDR_READBACK      = 16'h001c;

  localparam logic [31:0] CURRENT_SCALE_RESET = 32'h0000_03e8;
  localparam logic [15:0] SOURCE_SELECT_RESET = 16'h0000;
  localparam logic [15:0] SOURCE_SELECT_MAX   = 16'h000b;
  localparam logic [15:0] OFFSET_RESET        = 16'h0000;

  // ****************************************
  // voltage coding
  // ****************************************
  localparam int                 FULL_SWING_VOLTS = 10;
  localparam logic signed [15:0] VOLT_POS_FULL    = 16'sh7fff;
  localparam logic signed [15:0] VOLT_NEG_FULL    = 16'sh8001;
  localparam logic        [14:0] VOLT_MAG_FULL    = 15'h7fff;

  localparam int QTY_W      = 32;
  localparam int DIVIDEND_W = 48;

  // ****************************************
  // sources and states
  // ****************************************
  typedef enum logic [3:0] {
    SRC_USER, SRC_VEL_ACTUAL, SRC_VEL_ERROR, SRC_VEL_COMMAND,
    SRC_CUR_ACTUAL, SRC_CUR_COMMAND, SRC_POS_ACTUAL, SRC_POS_ERROR,
    SRC_TRIANGLE, SRC_DEBUG, SRC_VEL_RAW, SRC_VEL_LOWPASS
  } source_e;

  typedef enum logic [1:0] {
    ST_SAMPLE, ST_DIVIDE, ST_FINISH
  } conv_state_e;

endpackage : analog_out_pkg

`default_nettype wire

//--- verilog/ratio_divider.sv
/*
  Iterative restoring divider, one quotient bit per clock.
  Assumes start is a one-cycle pulse given only while busy is low.
*/
`default_nettype none

module ratio_divider #(
  parameter int NW = 48,
  parameter int DW = 32
) (
  input  wire logic          sys_clk,
  input  wire logic          sys_rst,
  input  wire logic          start,
  input  wire logic [NW-1:0] dividend,
  input  wire logic [DW-1:0] divisor,
  output logic      [NW-1:0] quotient,
  output logic               done,
  output logic               busy
);

  localparam int CW = $clog2(NW + 1);

  logic [DW-1:0] rem_reg;
  logic [DW-1:0] div_reg;
  logic [CW-1:0] count_reg;
  logic [DW:0]   trial;
  logic          fits;

  assign trial = {rem_reg, quotient[NW-1]};
  assign fits  = trial >= {1'b0, div_reg};

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rem_reg   <= '0;
      div_reg   <= '0;
      count_reg <= '0;
      quotient  <= '0;
      done      <= 1'b0;
      busy      <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start && divisor == '0) begin
        // a zero scale means infinite gain: let the caller saturate
        quotient <= '1;
        done     <= 1'b1;
      end else if (start) begin
        rem_reg   <= '0;
        div_reg   <= divisor;
        quotient  <= dividend;
        count_reg <= CW'(NW);
        busy      <= 1'b1;
      end else if (busy) begin
        rem_reg   <= fits ? DW'(trial - {1'b0, div_reg}) : trial[DW-1:0];
        quotient  <= {quotient[NW-2:0], fits};
        count_reg <= count_reg - 1'b1;
        if (count_reg == CW'(1)) begin
          busy <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end

endmodule : ratio_divider

`default_nettype wire

//--- verilog/triangle_wave.sv
/*
  Triangle wave source ramping between the two full-scale codes.
  Assumes a single clock; the ramp rate comes from an enable divider.
*/
`default_nettype none

module triangle_wave #(
  parameter int                 STEP_DIV = 2000,
  parameter logic signed [15:0] STEP     = 16'sh0040,
  parameter logic signed [15:0] TOP      = 16'sh7fff,
  parameter logic signed [15:0] BOTTOM   = 16'sh8001
) (
  input  wire logic               sys_clk,
  input  wire logic               sys_rst,
  output logic signed [15:0]      wave
);

  localparam int CW = $clog2(STEP_DIV + 1);

  logic [CW-1:0]      div_reg;
  logic               step_en;
  logic               rising_reg;
  logic signed [16:0] up_sum;
  logic signed [16:0] down_sum;

  assign step_en  = div_reg == CW'(STEP_DIV - 1);
  assign up_sum   = 17'(wave) + 17'(STEP);
  assign down_sum = 17'(wave) - 17'(STEP);

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      div_reg <= '0;
    end else begin
      div_reg <= step_en ? '0 : div_reg + 1'b1;
    end
  end

  // turn at the rails so the ramp never overshoots full scale
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      wave       <= '0;
      rising_reg <= 1'b1;
    end else if (step_en && rising_reg) begin
      if (up_sum >= 17'(TOP)) begin
        wave       <= TOP;
        rising_reg <= 1'b0;
      end else begin
        wave <= up_sum[15:0];
      end
    end else if (step_en) begin
      if (down_sum <= 17'(BOTTOM)) begin
        wave       <= BOTTOM;
        rising_reg <= 1'b1;
      end else begin
        wave <= down_sum[15:0];
      end
    end
  end

endmodule : triangle_wave

`default_nettype wire

//--- verilog/analog_output_source_select.sv
/*
  Analog output source select: picks the drive quantity for the output
  converter, scales it per 10 V, adds the offset and saturates.
  Assumes all quantities and limits come from logic on sys_clk, and that
  the parameter port is driven by the drive's parameter handler.
*/
`default_nettype none

module analog_output_source_select
  import analog_out_pkg::*;
#(
  parameter int TRI_STEP_DIV = 2000
) (
  input  wire logic                            sys_clk,
  input  wire logic                            sys_rst,
  input  wire logic [15:0]                     param_addr,
  input  wire logic [31:0]                     param_wdata,
  input  wire logic                            param_wr,
  input  wire logic                            param_rd,
  output logic      [31:0]                     param_rdata,
  output logic                                 param_ack,
  output logic                                 param_err,
  input  wire logic signed [15:0]              user_output_value,
  input  wire logic signed [15:0]              debug_value,
  input  wire logic signed [analog_out_pkg::QTY_W-1:0] velocity_feedback,
  input  wire logic signed [analog_out_pkg::QTY_W-1:0] velocity_error,
  input  wire logic signed [analog_out_pkg::QTY_W-1:0] velocity_command,
  input  wire logic signed [analog_out_pkg::QTY_W-1:0] actual_current,
  input  wire logic signed [analog_out_pkg::QTY_W-1:0] current_command,
  input  wire logic signed [analog_out_pkg::QTY_W-1:0] actual_position,
  input  wire logic signed [analog_out_pkg::QTY_W-1:0] position_error,
  input  wire logic signed [analog_out_pkg::QTY_W-1:0] raw_velocity_feedback,
  input  wire logic signed [analog_out_pkg::QTY_W-1:0] lowpass_velocity_feedback,
  input  wire logic signed [analog_out_pkg::QTY_W-1:0] positive_current_limit,
  input  wire logic signed [analog_out_pkg::QTY_W-1:0] negative_current_limit,
  input  wire logic [analog_out_pkg::QTY_W-1:0]        velocity_scale_factor,
  input  wire logic [analog_out_pkg::QTY_W-1:0]        position_scale_factor,
  output logic signed [15:0]                   analog_out_code,
  output logic                                 analog_out_strobe,
  output logic [15:0]                          debug_select
);

  import analog_out_pkg::*;

  // ****************************************
  // parameter registers
  // ****************************************
  logic [31:0]        current_scale_factor_reg;
  logic [15:0]        output_source_select_reg;
  logic signed [15:0] output_offset_volts_reg;

  logic               hit_scale;
  logic               hit_select;
  logic               hit_offset;
  logic               hit_readback;
  logic               hit_any;
  logic               select_ok;
  logic signed [15:0] offset_wdata;
  logic [31:0]        read_mux;

  assign hit_scale    = param_addr == ADDR_CURRENT_SCALE;
  assign hit_select   = param_addr == ADDR_SOURCE_SELECT;
  assign hit_offset   = param_addr == ADDR_OFFSET;
  assign hit_readback = param_addr == ADDR_READBACK;
  assign hit_any      = hit_scale | hit_select | hit_offset | hit_readback;
  assign select_ok    = param_wdata[31:0] <= 32'(SOURCE_SELECT_MAX);
  // the one code beyond -10 V is pulled back onto the rail
  assign offset_wdata = ($signed(param_wdata[15:0]) < VOLT_NEG_FULL) ?
                        VOLT_NEG_FULL : $signed(param_wdata[15:0]);

  assign read_mux = hit_scale    ? current_scale_factor_reg :
                    hit_select   ? {16'h0000, output_source_select_reg} :
                    hit_offset   ? {{16{output_offset_volts_reg[15]}}, output_offset_volts_reg} :
                    hit_readback ? {{16{analog_out_code[15]}}, analog_out_code} :
                    32'h0000_0000;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      current_scale_factor_reg <= CURRENT_SCALE_RESET;
      output_source_select_reg <= SOURCE_SELECT_RESET;
      output_offset_volts_reg  <= OFFSET_RESET;
    end else if (param_wr) begin
      // no range check: any gain above or below rated current is taken
      if (hit_scale) current_scale_factor_reg <= param_wdata;
      if (hit_select && select_ok) output_source_select_reg <= param_wdata[15:0];
      if (hit_offset) output_offset_volts_reg <= offset_wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      param_rdata <= '0;
      param_ack   <= 1'b0;
      param_err   <= 1'b0;
    end else begin
      param_ack <= param_wr | param_rd;
      param_err <= (param_wr | param_rd) & ~hit_any |
                   param_wr & (hit_readback | hit_select & ~select_ok);
      if (param_rd) param_rdata <= read_mux;
    end
  end

  // ****************************************
  // source selection
  // ****************************************
  source_e                   src;
  logic signed [QTY_W-1:0]   cur_raw;
  logic signed [QTY_W-1:0]   cur_clamped;
  logic signed [QTY_W-1:0]   quantity;
  logic [QTY_W-1:0]          scale;
  logic                      is_current;
  logic                      is_velocity;
  logic                      is_position;
  logic                      needs_scale;
  logic signed [15:0]        direct_volts;
  logic signed [15:0]        tri_value;
  logic                      qty_neg;
  logic [QTY_W-1:0]          qty_mag;
  logic [DIVIDEND_W-1:0]     dividend;

  assign src = source_e'(output_source_select_reg[3:0]);

  assign is_current  = src == SRC_CUR_ACTUAL || src == SRC_CUR_COMMAND;
  assign is_velocity = src == SRC_VEL_ACTUAL || src == SRC_VEL_ERROR ||
                       src == SRC_VEL_COMMAND || src == SRC_VEL_RAW ||
                       src == SRC_VEL_LOWPASS;
  assign is_position = src == SRC_POS_ACTUAL || src == SRC_POS_ERROR;
  assign needs_scale = is_current | is_velocity | is_position;

  assign cur_raw = (src == SRC_CUR_ACTUAL) ? actual_current : current_command;
  // limits clamp the current before scaling, whatever the gain
  assign cur_clamped = (cur_raw > positive_current_limit) ? positive_current_limit :
                       (cur_raw < negative_current_limit) ? negative_current_limit :
                       cur_raw;

  assign quantity = (src == SRC_VEL_ACTUAL)  ? velocity_feedback :
                    (src == SRC_VEL_ERROR)   ? velocity_error :
                    (src == SRC_VEL_COMMAND) ? velocity_command :
                    is_current               ? cur_clamped :
                    (src == SRC_POS_ACTUAL)  ? actual_position :
                    (src == SRC_POS_ERROR)   ? position_error :
                    (src == SRC_VEL_RAW)     ? raw_velocity_feedback :
                    lowpass_velocity_feedback;

  assign scale = is_current  ? current_scale_factor_reg :
                 is_position ? position_scale_factor :
                 velocity_scale_factor;

  assign direct_volts = (src == SRC_TRIANGLE) ? tri_value :
                        (src == SRC_DEBUG)    ? debug_value :
                        user_output_value;

  assign qty_neg  = quantity[QTY_W-1];
  assign qty_mag  = qty_neg ? QTY_W'(-quantity) : QTY_W'(quantity);
  // scale is the quantity per full 10 V, so volts = q * full_code / scale
  assign dividend = DIVIDEND_W'(qty_mag) * DIVIDEND_W'(VOLT_MAG_FULL);

  triangle_wave #(
    .STEP_DIV (TRI_STEP_DIV),
    .TOP      (VOLT_POS_FULL),
    .BOTTOM   (VOLT_NEG_FULL)
  ) u_triangle (
    .sys_clk  (sys_clk),
    .sys_rst  (sys_rst),
    .wave     (tri_value)
  );

  // ****************************************
  // scaling sequence
  // ****************************************
  conv_state_e           state_reg;
  logic                  neg_reg;
  logic                  div_start;
  logic                  div_done;
  logic [DIVIDEND_W-1:0] quotient;
  logic signed [15:0]    pre_volts_reg;
  logic [14:0]           mag_sat;
  logic signed [16:0]    sum;
  logic signed [15:0]    sum_sat;

  assign div_start = state_reg == ST_SAMPLE && needs_scale;
  assign mag_sat   = (quotient > DIVIDEND_W'(VOLT_MAG_FULL)) ?
                     VOLT_MAG_FULL : quotient[14:0];
  assign sum       = 17'(pre_volts_reg) + 17'(output_offset_volts_reg);
  assign sum_sat   = (sum > 17'(VOLT_POS_FULL)) ? VOLT_POS_FULL :
                     (sum < 17'(VOLT_NEG_FULL)) ? VOLT_NEG_FULL :
                     sum[15:0];

  ratio_divider #(
    .NW        (DIVIDEND_W),
    .DW        (QTY_W)
  ) u_divider (
    .sys_clk   (sys_clk),
    .sys_rst   (sys_rst),
    .start     (div_start),
    .dividend  (dividend),
    .divisor   (scale),
    .quotient  (quotient),
    .done      (div_done),
    .busy      ()
  );

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_reg     <= ST_SAMPLE;
      neg_reg       <= 1'b0;
      pre_volts_reg <= '0;
    end else begin
      unique case (state_reg)
        ST_SAMPLE: begin
          neg_reg <= qty_neg;
          if (needs_scale) begin
            state_reg <= ST_DIVIDE;
          end else begin
            pre_volts_reg <= direct_volts;
            state_reg     <= ST_FINISH;
          end
        end
        ST_DIVIDE: begin
          if (div_done) begin
            pre_volts_reg <= neg_reg ? -$signed({1'b0, mag_sat}) : $signed({1'b0, mag_sat});
            state_reg     <= ST_FINISH;
          end
        end
        ST_FINISH: begin
          state_reg <= ST_SAMPLE;
        end
      endcase
    end
  end

  // ****************************************
  // converter outputs
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      analog_out_code   <= '0;
      analog_out_strobe <= 1'b0;
      debug_select      <= '0;
    end else begin
      analog_out_strobe <= state_reg == ST_FINISH;
      if (state_reg == ST_FINISH) analog_out_code <= sum_sat;
      debug_select <= user_output_value;
    end
  end

endmodule : analog_output_source_select

`default_nettype wire

//--- tb/analog_output_source_select_checker.sv
/*
  Port checker for analog_output_source_select, bound to the design.
  Assumes one clock sys_clk and synchronous active-high sys_rst.
*/
`default_nettype none

module analog_output_source_select_checker
  import analog_out_pkg::*;
(
  input wire logic               sys_clk,
  input wire logic               sys_rst,
  input wire logic [15:0]        param_addr,
  input wire logic [31:0]        param_wdata,
  input wire logic               param_wr,
  input wire logic               param_rd,
  input wire logic [31:0]        param_rdata,
  input wire logic               param_ack,
  input wire logic               param_err,
  input wire logic signed [15:0] user_output_value,
  input wire logic signed [15:0] analog_out_code,
  input wire logic               analog_out_strobe,
  input wire logic [15:0]        debug_select
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  // ********
  // helpers
  // ********
  wire logic mapped = param_addr inside {ADDR_CURRENT_SCALE, ADDR_SOURCE_SELECT,
                                         ADDR_OFFSET, ADDR_READBACK};
  sequence s_any_req;
    param_wr || param_rd;
  endsequence
  // unscaled sources loop sample/finish, so strobes may come every other cycle
  sequence s_gap;
    !analog_out_strobe;
  endsequence

  // ********
  // assertions
  // ********
  a_ack_follows_req: assert property (s_any_req |=> param_ack)
    else $error("ack missing after request");
  a_ack_has_cause: assert property (param_ack |-> $past(param_wr || param_rd))
    else $error("ack without request");
  a_err_with_ack: assert property (param_err |-> param_ack)
    else $error("err without ack");
  a_bad_select_err: assert property (param_wr && param_addr == ADDR_SOURCE_SELECT
    && param_wdata > {16'h0000, SOURCE_SELECT_MAX} |=> param_err)
    else $error("select above 11 accepted");
  a_unmapped_read: assert property (param_rd && !mapped
    |=> param_err && param_rdata == 32'h0000_0000)
    else $error("unmapped read not refused");
  a_select_in_range: assert property (param_rd && param_addr == ADDR_SOURCE_SELECT
    |=> param_rdata <= {16'h0000, SOURCE_SELECT_MAX})
    else $error("selector out of range");
  a_offset_no_wrap: assert property (param_rd && param_addr == ADDR_OFFSET
    |=> param_rdata != 32'hffff_8000 && param_rdata[31:16] == {16{param_rdata[15]}})
    else $error("offset readback malformed");
  a_code_no_wrap: assert property (analog_out_code != 16'sh8000)
    else $error("output code 8000");
  a_code_holds: assert property (!analog_out_strobe |-> $stable(analog_out_code))
    else $error("code changed without strobe");
  a_strobe_spacing: assert property (analog_out_strobe |=> s_gap)
    else $error("strobes too close");
  a_debug_copy: assert property (!$past(sys_rst)
    |-> debug_select == $past(user_output_value))
    else $error("debug select not copied");
endmodule : analog_output_source_select_checker

bind analog_output_source_select analog_output_source_select_checker u_chk (
  .sys_clk(sys_clk), .sys_rst(sys_rst), .param_addr(param_addr),
  .param_wdata(param_wdata), .param_wr(param_wr), .param_rd(param_rd),
  .param_rdata(param_rdata), .param_ack(param_ack), .param_err(param_err),
  .user_output_value(user_output_value), .analog_out_code(analog_out_code),
  .analog_out_strobe(analog_out_strobe), .debug_select(debug_select));

`default_nettype wire

//--- tb/analog_converter_model.sv
/*
  Output converter model: latches the code on each strobe, counts updates.
  Assumes code and strobe come from logic on sys_clk.
*/
`default_nettype none

module analog_converter_model (
  input  wire logic               sys_clk,
  input  wire logic               sys_rst,
  input  wire logic signed [15:0] code,
  input  wire logic               strobe,
  output logic signed [15:0]      held_code,
  output int unsigned             updates
);
  timeunit 1ns;
  timeprecision 1ps;
  // only strobed codes count, a stale code between strobes is never seen
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      held_code <= 16'sh0000;
      updates   <= 0;
    end else if (strobe) begin
      held_code <= code;
      updates   <= updates + 1;
    end
  end
endmodule : analog_converter_model

`default_nettype wire

//--- tb/analog_output_source_select_tb_top.sv
/*
  Self-checking bench for analog_output_source_select.
  Assumes the package is compiled first and the checker is bound.
*/
`default_nettype none

module analog_output_source_select_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import analog_out_pkg::*;

  logic               sys_clk = 1'b0, sys_rst = 1'b1;
  logic [15:0]        param_addr = 16'h0000;
  logic [31:0]        param_wdata = 32'h0000_0000;
  logic               param_wr = 1'b0, param_rd = 1'b0;
  logic [31:0]        param_rdata;
  logic               param_ack, param_err, analog_out_strobe;
  logic signed [15:0] user_val = 16'sh1234, dbg = -16'sh0567, analog_out_code, held;
  logic [15:0]        debug_select;
  logic signed [31:0] vfb = 1000, verr = -500, vcmd = 2000, cur = 5000, ccmd = -6000;
  logic signed [31:0] pos = 8000, perr = -1200, vraw = 300, vlp = -700;
  logic signed [31:0] plim = 3000, nlim = -2500;
  logic [31:0]        vsc = 4000, psc = 16000;
  int unsigned        updates;
  int                 errors = 0, samples_checked = 0;
  logic [31:0]        q;
  logic               e;

  always #2.5 sys_clk = ~sys_clk;

  analog_output_source_select #(.TRI_STEP_DIV(2)) dut (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .param_addr(param_addr),
    .param_wdata(param_wdata), .param_wr(param_wr), .param_rd(param_rd),
    .param_rdata(param_rdata), .param_ack(param_ack), .param_err(param_err),
    .user_output_value(user_val), .debug_value(dbg), .velocity_feedback(vfb),
    .velocity_error(verr), .velocity_command(vcmd), .actual_current(cur),
    .current_command(ccmd), .actual_position(pos), .position_error(perr),
    .raw_velocity_feedback(vraw), .lowpass_velocity_feedback(vlp),
    .positive_current_limit(plim), .negative_current_limit(nlim),
    .velocity_scale_factor(vsc), .position_scale_factor(psc),
    .analog_out_code(analog_out_code), .analog_out_strobe(analog_out_strobe),
    .debug_select(debug_select));

  analog_converter_model conv (.sys_clk(sys_clk), .sys_rst(sys_rst), .code(analog_out_code),
    .strobe(analog_out_strobe), .held_code(held), .updates(updates));

  // ********
  // helpers
  // ********
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    samples_checked++;
    if (g !== x) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, g, x);
    end
  endtask : chk

  task automatic acc(input logic w, input logic [15:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    param_addr <= a;
    param_wdata <= d;
    param_wr <= w;
    param_rd <= !w;
    @(posedge sys_clk);
    param_wr <= 1'b0;
    param_rd <= 1'b0;
    #1;
    q = param_rdata;
    e = param_err;
    chk({31'h0, param_ack}, 32'h1);
  endtask : acc

  // three strobes: the first may still carry the previous selection
  task automatic settle;
    int n0, k;
    n0 = updates;
    k = 0;
    while (updates < n0 + 3 && k < 1000) begin
      @(posedge sys_clk);
      k++;
    end
    if (k >= 1000) chk(32'h0, 32'h1);
    #1;
  endtask : settle

  // sign-magnitude scaling per full swing, then offset, then saturation
  function automatic logic [31:0] ec(input longint v, input longint s, input longint off);
    longint m, r;
    m = (v < 0) ? -v : v;
    if (s != 0) m = (m * 32767 / s > 32767) ? 32767 : m * 32767 / s;
    r = ((v < 0) ? -m : m) + off;
    r = (r > 32767) ? 32767 : (r < -32767) ? -32767 : r;
    return {{16{r[15]}}, r[15:0]};
  endfunction : ec

  // ********
  // scenarios
  // ********
  task automatic t_reset_values;
    acc(0, ADDR_CURRENT_SCALE, 0); chk(q, {CURRENT_SCALE_RESET});
    acc(0, ADDR_SOURCE_SELECT, 0); chk(q, {16'h0, SOURCE_SELECT_RESET});
    acc(0, ADDR_OFFSET, 0); chk(q, {16'h0, OFFSET_RESET});
  endtask : t_reset_values

  task automatic t_refusals;
    acc(1, ADDR_SOURCE_SELECT, 32'hc); chk({31'h0, e}, 32'h1);
    acc(0, ADDR_SOURCE_SELECT, 0); chk(q, 32'h0);
    acc(0, 16'h0020, 0); chk({e, q[30:0]}, 32'h8000_0000);
    acc(1, ADDR_READBACK, 32'h5); chk({31'h0, e}, 32'h1);
  endtask : t_refusals

  task automatic t_sources;
    logic signed [15:0] prev;
    acc(1, ADDR_CURRENT_SCALE, 32'd10000); chk({31'h0, e}, 32'h0);
    for (int m = 0; m < 12; m++) begin
      acc(1, ADDR_SOURCE_SELECT, m);
      settle();
      case (m)
        0: chk({{16{held[15]}}, held}, ec(user_val, 0, 0));
        1: chk({{16{held[15]}}, held}, ec(vfb, vsc, 0));
        2: chk({{16{held[15]}}, held}, ec(verr, vsc, 0));
        3: chk({{16{held[15]}}, held}, ec(vcmd, vsc, 0));
        4: chk({{16{held[15]}}, held}, ec(plim, 10000, 0));
        5: chk({{16{held[15]}}, held}, ec(nlim, 10000, 0));
        6: chk({{16{held[15]}}, held}, ec(pos, psc, 0));
        7: chk({{16{held[15]}}, held}, ec(perr, psc, 0));
        8: begin
          prev = held;
          settle();
          chk({31'h0, prev !== held}, 32'h1);
        end
        9: chk({{16{held[15]}}, held}, ec(dbg, 0, 0));
        10: chk({{16{held[15]}}, held}, ec(vraw, vsc, 0));
        default: chk({{16{held[15]}}, held}, ec(vlp, vsc, 0));
      endcase
    end
  endtask : t_sources

  task automatic t_current_overrange;
    acc(1, ADDR_CURRENT_SCALE, 32'd100);
    acc(1, ADDR_SOURCE_SELECT, 4);
    settle(); chk({{16{held[15]}}, held}, 32'h0000_7fff);
  endtask : t_current_overrange

  task automatic t_offset_sat;
    acc(1, ADDR_SOURCE_SELECT, 0);
    @(posedge sys_clk) user_val <= 16'sh7000;
    acc(1, ADDR_OFFSET, 32'h2000);
    settle(); chk({{16{held[15]}}, held}, 32'h0000_7fff);
    acc(0, ADDR_READBACK, 0); chk(q, 32'h0000_7fff);
    @(posedge sys_clk) user_val <= -16'sh7000;
    acc(1, ADDR_OFFSET, 32'h8000);
    acc(0, ADDR_OFFSET, 0); chk(q, 32'hffff_8001);
    settle(); chk({{16{held[15]}}, held}, 32'hffff_8001);
  endtask : t_offset_sat

  task automatic conclude;
    $display("checks %0d, errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : conclude

  initial begin
    repeat (4) @(posedge sys_clk);
    sys_rst <= 1'b0;
    t_reset_values();
    t_refusals();
    t_sources();
    t_current_overrange();
    t_offset_sat();
    conclude();
  end

  // whole run needs under two thousand cycles
  initial begin
    #250000;
    errors++;
    conclude();
  end
endmodule : analog_output_source_select_tb_top

`default_nettype wire
